// [bench/pdw_bridge_props.sv]
// Purpose: Port checks for pdw_bridge
// Assumes: One clock, sync reset
// Notes: Bound below
`timescale 1ns/1ps
module pdw_bridge_props #(parameter logic [27:0] RANGE_RESET = pdw_pkg::RANGE_2MB) (
   input wire logic clk,
   input wire logic rst,
   input wire pdw_pkg::pdw_reg_req_t reg_req,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire pdw_pkg::pdw_dma_cmd_t dma_cmd,
   input wire logic dma_int_clear,
   input wire logic [31:0] host_base,
   input wire pdw_pkg::pdw_slv_req_t slv_req,
   input wire pdw_pkg::pdw_loc_req_t loc_req
);
   import pdw_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic [31:0] msk = {RANGE_RESET, 4'h0};
   wire logic go = reg_req.wr && reg_req.addr == OFF_DMA0_CSR;
   wire logic hit = ((slv_req.addr ^ host_base) & msk) == 32'h0;
   start_gate_a: assert property (dma_cmd.start |-> $past(go && reg_req.wdata[1:0] == 2'h3))
      else $error("start without enabled start write");
   clear_pulse_a: assert property (dma_int_clear == $past(go && reg_req.wdata[3]))
      else $error("bad interrupt clear pulse");
   start_launch_a: assert property (go && reg_req.wdata[1:0] == 2'h3 |=> dma_cmd.start)
      else $error("enabled start write did not launch");
   disabled_start_a: assert property (go && !reg_req.wdata[0] |=> !dma_cmd.start)
      else $error("disabled channel started");
   dual_flag_a: assert property (dma_cmd.dual_addr == (dma_cmd.upper != 32'h0))
      else $error("dual address flag wrong");
   upper_load_a: assert property (reg_req.wr && reg_req.addr == OFF_DMA0_UPPER |=>
      dma_cmd.upper == $past(reg_req.wdata)) else $error("upper not loaded");
   read_valid_a: assert property (reg_req.rd |=> reg_rvalid) else $error("no read answer");
   csr_read_a: assert property (reg_req.rd && reg_req.addr == OFF_DMA0_CSR |=>
      (reg_rdata & 32'hffff_ffee) == 32'h0) else $error("status reserved bits set");
   remap_read_a: assert property (reg_req.rd && reg_req.addr == OFF_WIN_REMAP |=>
      reg_rdata[3:0] == 4'h1) else $error("remap low bits wrong");
   range_read_a: assert property (reg_req.rd && reg_req.addr == OFF_WIN_RANGE |=>
      reg_rdata == msk) else $error("range read wrong");
   hit_fwd_a: assert property (slv_req.valid && hit |=> loc_req.valid &&
      (loc_req.addr & ~msk) == ($past(slv_req.addr) & ~msk)) else $error("hit not forwarded");
   miss_drop_a: assert property (slv_req.valid && !hit |=> !loc_req.valid)
      else $error("miss forwarded");
endmodule : pdw_bridge_props
bind pdw_bridge pdw_bridge_props #(.RANGE_RESET(RANGE_RESET)) props (.clk(clk), .rst(rst),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .dma_cmd(dma_cmd),
   .dma_int_clear(dma_int_clear), .host_base(host_base), .slv_req(slv_req), .loc_req(loc_req));

// [bench/pdw_engine_model.sv]
// Purpose: Transfer engine stand-in
// Assumes: One start pulse per launch
// Notes: Done pulse DLY+1 cycles after the start pulse
`timescale 1ns/1ps
module pdw_engine_model #(parameter int DLY = 5) (
   input wire logic clk,
   input wire logic rst,
   input wire pdw_pkg::pdw_dma_cmd_t dma_cmd,
   output logic dma_done
);
   import pdw_pkg::*;
   int cnt;
   always_ff @(posedge clk) begin
      dma_done <= cnt == 1;
      if (rst) cnt <= 0;
      else if (dma_cmd.start) cnt <= DLY;
      else if (cnt > 0) cnt <= cnt - 1;
   end
endmodule : pdw_engine_model

// [bench/tb.sv]
// Purpose: Register and window tests
// Assumes: Inputs change at falling edge
// Notes: Engine model returns done
`timescale 1ns/1ps
module tb;
   import pdw_pkg::*;
   localparam logic [31:0] MSK = {RANGE_2MB, 4'h0};
   logic clk = 0, rst = 1, dma_done, dma_int_clear, reg_rvalid;
   logic [31:0] reg_rdata, host_base = 32'h8000_0000;
   pdw_reg_req_t q = '0;
   pdw_slv_req_t s = '0;
   pdw_loc_req_t loc_req;
   pdw_dma_cmd_t dma_cmd;
   int err_total = 0, tests_run = 0, cyc = 0;
   pdw_bridge DUT (.clk(clk), .rst(rst), .reg_req(q), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .dma_done(dma_done), .dma_cmd(dma_cmd),
      .dma_int_clear(dma_int_clear), .host_base(host_base), .slv_req(s), .loc_req(loc_req));
   pdw_engine_model eng (.clk(clk), .rst(rst), .dma_cmd(dma_cmd), .dma_done(dma_done));
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk) q = '{1'b1, 1'b0, a, d};
      @(negedge clk) q.wr = 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(negedge clk) q = '{1'b0, 1'b1, a, 32'h0};
      @(negedge clk) q.rd = 0;
      chk(reg_rvalid, 1);
      chk(reg_rdata, e);
   endtask : rd
   task automatic slv(input logic [31:0] a, input logic v, input logic [31:0] e);
      @(negedge clk) s = '{1'b1, a};
      @(negedge clk) s.valid = 0;
      chk(loc_req.valid, v);
      if (v) chk(loc_req.addr, e);
   endtask : slv
   task automatic summarize();
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   // Hang guard, run needs about a hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      repeat (16) @(negedge clk);
      rst = 0;
      rd(OFF_DMA0_CSR, 32'h10);
      rd(OFF_DMA0_UPPER, 32'h0);
      rd(OFF_WIN_RANGE, MSK);
      rd(OFF_WIN_REMAP, 32'h1);
      rd(8'h40, 32'h0);
      wr(OFF_WIN_RANGE, 32'hffff_ffff);
      rd(OFF_WIN_RANGE, MSK);
      wr(OFF_DMA0_CSR, 32'h2);
      rd(OFF_DMA0_CSR, 32'h10);
      wr(OFF_DMA0_CSR, 32'h3);
      rd(OFF_DMA0_CSR, 32'h1);
      repeat (8) @(negedge clk);
      rd(OFF_DMA0_CSR, 32'h11);
      // Third launch lands on the completion pulse of the second
      wr(OFF_DMA0_CSR, 32'h3);
      rd(OFF_DMA0_CSR, 32'h1);
      repeat (3) @(negedge clk);
      wr(OFF_DMA0_CSR, 32'h3);
      rd(OFF_DMA0_CSR, 32'h11);
      wr(OFF_DMA0_CSR, 32'h9);
      rd(OFF_DMA0_CSR, 32'h11);
      wr(OFF_DMA0_UPPER, 32'h1234_5678);
      rd(OFF_DMA0_UPPER, 32'h1234_5678);
      chk(dma_cmd.dual_addr, 1);
      wr(OFF_DMA0_UPPER, 32'h0);
      rd(OFF_DMA0_UPPER, 32'h0);
      chk(dma_cmd.dual_addr, 0);
      // Remap kept a multiple of the window size
      wr(OFF_WIN_REMAP, 32'h0020_0000);
      rd(OFF_WIN_REMAP, 32'h0020_0001);
      slv(32'h8001_2344, 1, 32'h0021_2344);
      slv(32'h8040_0000, 0, 32'h0);
      // Moved base: old window must miss, new one hit
      @(negedge clk) host_base = 32'h9000_0000;
      slv(32'h8001_2344, 0, 32'h0);
      slv(32'h901f_fff0, 1, 32'h003f_fff0);
      // Mid-run reset must restore every field
      wr(OFF_DMA0_UPPER, 32'h5a5a_0000);
      @(negedge clk) rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      rd(OFF_DMA0_CSR, 32'h10);
      rd(OFF_DMA0_UPPER, 32'h0);
      chk(dma_cmd.dual_addr, 0);
      rd(OFF_WIN_REMAP, 32'h1);
      summarize();
   end
endmodule : tb

// [include/pdw_pkg.sv]
// Purpose: Shared constants and carriers for the DMA control and slave window block
// Assumes: 32-bit register data, byte offsets as printed
// Notes: Range mask reset chosen by window size parameter in the top
package pdw_pkg;
   localparam logic [7:0] OFF_DMA0_CSR = 8'ha8;
   localparam logic [7:0] OFF_DMA0_UPPER = 8'hb4;
   localparam logic [7:0] OFF_WIN_RANGE = 8'hf0;
   localparam logic [7:0] OFF_WIN_REMAP = 8'hf4;
   localparam int CSR_ENABLE_BIT = 0;
   localparam int CSR_START_BIT = 1;
   localparam int CSR_CLRINT_BIT = 3;
   localparam int CSR_DONE_BIT = 4;
   localparam logic RST_ENABLE = 1'b0;
   localparam logic RST_DONE = 1'b1;
   localparam logic RST_WIN_EN = 1'b1;
   localparam logic [31:0] RST_UPPER = 32'h0000_0000;
   localparam logic [27:0] RST_REMAP = 28'h000_0000;
   localparam logic [27:0] RANGE_2MB = 28'hffe_0000;
   localparam logic [27:0] RANGE_256MB = 28'hf00_0000;

   // Register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } pdw_reg_req_t;

   // Host-side slave access as seen on the PCI side
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } pdw_slv_req_t;

   // Forwarded local access
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } pdw_loc_req_t;

   // Launch toward the transfer engine
   typedef struct packed {
      logic start;
      logic dual_addr;
      logic [31:0] upper;
   } pdw_dma_cmd_t;
endpackage : pdw_pkg

// [rtl/pdw_bridge.sv]
// Purpose: DMA channel 0 command/status and direct-slave window registers
// Assumes: Register port synchronous to clk; reads answer one cycle later
// Notes: Transfer engine lies outside and reports completion by pulse
//
// Overview of operation
// R1: Bit 0 enables channel, readable, resets zero
// R2: Disabled channel never begins a transfer
// R3: Bit 1 write starts enabled channel, reads zero
// R4: Bit 3 write clears channel interrupts
// R5: Bit 4 reads done, one after reset
// R6: Bits 2 and 7:5 read zero
// R7: Upper register feeds dual address cycle
// R8: Zero upper address means single cycle
// R9: Range bit 0 and 3:1 read zero
// R10: Range 31:4 read-only mask, size-dependent reset
// R11: Decoder compares only mask-one address bits
// R12: Remap bit 0 enables window, resets one; here hard-wired on, writes ignored
// R13: Offset forwarded above writable local base
// R14: Host keeps remap multiple of window size
// R15: Disabled start ignored; launch clears done; here a completion in the same cycle wins
`timescale 1ns/1ps
module pdw_bridge #(
   parameter logic [27:0] RANGE_RESET = pdw_pkg::RANGE_2MB
) (
   input wire logic clk,
   input wire logic rst,
   input wire pdw_pkg::pdw_reg_req_t reg_req,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic dma_done,
   output pdw_pkg::pdw_dma_cmd_t dma_cmd,
   output logic dma_int_clear,
   input wire logic [31:0] host_base,
   input wire pdw_pkg::pdw_slv_req_t slv_req,
   output pdw_pkg::pdw_loc_req_t loc_req
);
   import pdw_pkg::*;

   // -----------------------------
   // State
   // -----------------------------
   typedef struct packed {
      logic enable;
      logic done;
      logic [31:0] upper;
      logic [27:0] remap;
      logic [31:0] rdata;
      logic rvalid;
      pdw_dma_cmd_t cmd;
      logic int_clear;
   } pdw_state_t;

   pdw_state_t state_reg;
   pdw_state_t state_next;
   logic [7:0] csr_word;
   logic [7:0] wbyte;
   logic sel_csr;
   logic sel_upper;
   logic sel_range;
   logic sel_remap;
   logic csr_write;
   logic upper_write;
   logic remap_write;
   logic launch_req;
   logic clear_req;
   logic [31:0] csr_rword;
   logic [31:0] range_rword;
   logic [31:0] remap_rword;
   logic [31:0] read_word;
   logic [27:0] win_mask;
   logic win_enable;

   // -----------------------------
   // Address decode
   // -----------------------------
   always_comb begin
      sel_csr = 1'b0;
      sel_upper = 1'b0;
      sel_range = 1'b0;
      sel_remap = 1'b0;
      if (reg_req.addr == OFF_DMA0_CSR) begin
         sel_csr = 1'b1;
      end else if (reg_req.addr == OFF_DMA0_UPPER) begin
         sel_upper = 1'b1;
      end else if (reg_req.addr == OFF_WIN_RANGE) begin
         sel_range = 1'b1;
      end else if (reg_req.addr == OFF_WIN_REMAP) begin
         sel_remap = 1'b1;
      end
   end

   // -----------------------------
   // Write strobes
   // -----------------------------
   // A write and a read in one cycle both act; the read sees old data
   assign wbyte = reg_req.wdata[7:0];
   assign csr_write = reg_req.wr && sel_csr;
   assign upper_write = reg_req.wr && sel_upper;
   // No strobe for the range mask, it is fixed by the build [R10]
   assign remap_write = reg_req.wr && sel_remap;
   // Enable taken from the same byte, so one write may enable and start
   assign launch_req = csr_write && wbyte[CSR_START_BIT] && wbyte[CSR_ENABLE_BIT]; // [R2] [R3]
   assign clear_req = csr_write && wbyte[CSR_CLRINT_BIT]; // [R4]

   // -----------------------------
   // Read words
   // -----------------------------
   always_comb begin
      // Start and clear bits never read back [R3] [R4]
      csr_word = 8'h00;
      // Bit 2 and bits 7:5 stay zero [R6]
      csr_word[CSR_ENABLE_BIT] = state_reg.enable; // [R1]
      csr_word[CSR_DONE_BIT] = state_reg.done; // [R5]
      csr_rword = {24'h00_0000, csr_word};
      // Space indicator and reserved bits read zero [R9]
      range_rword = 32'h0000_0000;
      range_rword[31:4] = RANGE_RESET; // [R10]
      remap_rword = 32'h0000_0000;
      remap_rword[31:4] = state_reg.remap; // [R13]
      // Window enable is hard-wired on
      remap_rword[0] = RST_WIN_EN; // [R12]
      read_word = 32'h0000_0000;
      // Unmapped offsets read as zero
      if (sel_csr) begin
         read_word = csr_rword;
      end else if (sel_upper) begin
         read_word = state_reg.upper; // [R7]
      end else if (sel_range) begin
         read_word = range_rword;
      end else if (sel_remap) begin
         read_word = remap_rword;
      end
   end

   // -----------------------------
   // Next state
   // -----------------------------
   always_comb begin
      state_next = state_reg;
      // Start and clear are single-cycle pulses
      state_next.cmd.start = launch_req; // [R3]
      state_next.int_clear = clear_req; // [R4]
      state_next.rvalid = reg_req.rd;
      state_next.rdata = 32'h0000_0000;

      if (csr_write) begin
         state_next.enable = wbyte[CSR_ENABLE_BIT]; // [R1]
      end
      // A start with enable low leaves done set [R15]
      if (launch_req) begin
         state_next.done = 1'b0; // [R15]
      end
      // Completion wins over a launch in the same cycle
      if (dma_done) begin
         state_next.done = 1'b1; // [R5]
      end

      if (upper_write) begin
         state_next.upper = reg_req.wdata; // [R7]
      end
      if (remap_write) begin
         // Alignment to window size is left to software [R14]
         state_next.remap = reg_req.wdata[31:4]; // [R13]
      end
      // Launch carries the address that takes effect with it
      state_next.cmd.upper = state_next.upper; // [R7]
      state_next.cmd.dual_addr = (state_next.upper != 32'h0000_0000); // [R8]

      // Reads see the state before any write of the same cycle
      if (reg_req.rd) begin
         state_next.rdata = read_word;
      end

      if (rst) begin
         state_next.enable = RST_ENABLE; // [R1]
         state_next.done = RST_DONE; // [R5]
         state_next.upper = RST_UPPER; // [R8]
         state_next.remap = RST_REMAP; // [R13]
         state_next.rdata = 32'h0000_0000;
         state_next.rvalid = 1'b0;
         state_next.cmd.start = 1'b0;
         state_next.cmd.dual_addr = 1'b0;
         state_next.cmd.upper = RST_UPPER;
         state_next.int_clear = 1'b0;
      end
   end

   // -----------------------------
   // Registers
   // -----------------------------
   // Synchronous reset is folded into the next-state logic
   always_ff @(posedge clk) begin
      state_reg <= state_next;
   end

   // -----------------------------
   // Outputs
   // -----------------------------
   // All outputs are flop fields of the state
   assign reg_rdata = state_reg.rdata;
   assign reg_rvalid = state_reg.rvalid;
   assign dma_cmd = state_reg.cmd;
   assign dma_int_clear = state_reg.int_clear;

   // -----------------------------
   // Slave window
   // -----------------------------
   // Mask and enable are build constants; only the remap base is live
   // Decoder adds one cycle between host request and local request
   assign win_mask = RANGE_RESET;
   assign win_enable = RST_WIN_EN;

   pdw_window_decode u_decode (
      .clk(clk),
      .rst(rst),
      .slv_req(slv_req),
      .host_base(host_base),
      .range_mask(win_mask), // [R10]
      .local_base(state_reg.remap),
      .win_en(win_enable), // [R12]
      .loc_req(loc_req)
   );
endmodule : pdw_bridge

// [rtl/pdw_window_decode.sv]
// Purpose: Masked compare of a host address and remap onto local space 1
// Assumes: Mask and base are 28-bit fields for address bits 31:4
// Notes: Registered one cycle
`timescale 1ns/1ps
module pdw_window_decode (
   input wire logic clk,
   input wire logic rst,
   input wire pdw_pkg::pdw_slv_req_t slv_req,
   input wire logic [31:0] host_base,
   input wire logic [27:0] range_mask,
   input wire logic [27:0] local_base,
   input wire logic win_en,
   output pdw_pkg::pdw_loc_req_t loc_req
);
   import pdw_pkg::*;

   typedef struct packed {
      pdw_loc_req_t loc;
   } pdw_dec_state_t;

   pdw_dec_state_t state_reg;
   pdw_dec_state_t state_next;
   logic hit;
   logic [31:0] mask32;

   always_comb begin
      state_next = state_reg;
      mask32 = {range_mask, 4'h0};
      // Only mask-one bits take part in the compare [R11]
      hit = win_en && (((slv_req.addr ^ host_base) & mask32) == 32'h0);
      state_next.loc.valid = slv_req.valid && hit; // [R12]
      // Offset below the mask rides over onto the local base [R13]
      state_next.loc.addr = ({local_base, 4'h0} & mask32) | (slv_req.addr & ~mask32);
      if (rst) begin
         state_next = '0;
      end
   end

   always_ff @(posedge clk) begin
      state_reg <= state_next;
   end

   assign loc_req = state_reg.loc;
endmodule : pdw_window_decode
